// [logic/fesq_cfg.svh]
/*
 * Constants of the flash erase/write host sequencer: command codes,
 * status bit positions, register offsets, fields and pin timing.
 * Assumes a 25 MHz clock; included by bare name from the cycle engine, the host and the bench top.
 */
// Summary of operation
// - Host masks out reserved bit 0
// - Host clears status after error before retry
// - Command 70H enters status mode; poll bit 7
// - Block erase is 20H then D0H in block
// - Chip erase is 30H then D0H
// - Byte write is 40H or 10H then data
// - Errors checked per write or per batch
// - FFH returns device to read array
`ifndef FESQ_CFG_SVH
`define FESQ_CFG_SVH

`define FESQ_CMD_STATUS   8'h70
`define FESQ_CMD_BERASE   8'h20
`define FESQ_CMD_CERASE   8'h30
`define FESQ_CMD_WRITE    8'h40
`define FESQ_CMD_WRITE2   8'h10
`define FESQ_CMD_CONFIRM  8'hd0
`define FESQ_CMD_ARRAY    8'hff
`define FESQ_CMD_CLEAR    8'h50
`define FESQ_CMD_IDENT    8'h90

`define FESQ_SR_READY     7
`define FESQ_SR_ERASE     5
`define FESQ_SR_WRITE     4
`define FESQ_SR_PROT      1
`define FESQ_SR_MASK      8'hfe
`define FESQ_SR_ERRS      8'h3a

`define FESQ_OFS_CTRL     8'h00
`define FESQ_OFS_ADDR     8'h04
`define FESQ_OFS_WDATA    8'h08
`define FESQ_OFS_GO       8'h0c
`define FESQ_OFS_STAT     8'h10
`define FESQ_OFS_ACCUM    8'h14

`define FESQ_OP_STATUS    3'h0
`define FESQ_OP_BERASE    3'h1
`define FESQ_OP_CERASE    3'h2
`define FESQ_OP_WRITE     3'h3
`define FESQ_OP_CLEAR     3'h4
`define FESQ_OP_ARRAY     3'h5
`define FESQ_OP_LOCKRD    3'h6
`define FESQ_OP_READ      3'h7

`define FESQ_CTRL_ALT     3
`define FESQ_CTRL_AUTOCLR 4
`define FESQ_CTRL_BOOTOPEN 5
`define FESQ_CTRL_PDOWN   6

`define FESQ_CLK_MHZ      25
`define FESQ_WE_NS        60
`define FESQ_RD_NS        120
`define FESQ_REC_NS       40
`define FESQ_NS2CYC(ns)   (((ns) * `FESQ_CLK_MHZ + 999) / 1000)

`endif

// [logic/fesq_pkg.sv]
/*
 * Types of the flash erase/write host sequencer.
 * Assumes fesq_cfg.svh for the numbers; holds types only.
 */
package fesq_pkg;

    // One request to the pin cycle engine
    typedef struct packed {
        logic        we;
        logic [19:0] addr;
        logic [7:0]  data;
    } fesq_req_s;

    // Pin cycle phases
    typedef enum logic [2:0] {
        CYC_IDLE  = 3'b001,
        CYC_PULSE = 3'b010,
        CYC_REC   = 3'b100
    } fesq_cyc_e;

    // Sequencer steps
    typedef enum logic [9:0] {
        SQ_IDLE     = 10'h001,
        SQ_PRE_CMD  = 10'h002,
        SQ_PRE_POLL = 10'h004,
        SQ_SETUP    = 10'h008,
        SQ_CONFIRM  = 10'h010,
        SQ_POLL     = 10'h020,
        SQ_CLEAR    = 10'h040,
        SQ_EXIT     = 10'h080,
        SQ_ID_RD    = 10'h100,
        SQ_DONE     = 10'h200
    } fesq_seq_e;

endpackage : fesq_pkg

// [logic/fesq_sync2.sv]
/*
 * Two-flop synchroniser for pins read back from the flash.
 * Assumes the bus is stable while sampled; only the second flop is read.
 */
`timescale 1ns/1ps
module fesq_sync2 #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            q_o    <= '0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule : fesq_sync2

// [logic/fesq_flash_cycle.sv]
/*
 * Pin cycle engine: one asynchronous parallel read or write per request.
 * Assumes dq_i is already synchronised; one request outstanding at a time.
 */
`timescale 1ns/1ps
`include "fesq_cfg.svh"
module fesq_flash_cycle #(
    parameter int WE_CYC  = `FESQ_NS2CYC(`FESQ_WE_NS),
    parameter int RD_CYC  = `FESQ_NS2CYC(`FESQ_RD_NS),
    parameter int REC_CYC = `FESQ_NS2CYC(`FESQ_REC_NS)
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               req_i,
    input  wire fesq_pkg::fesq_req_s req_i_s,
    input  wire logic [7:0]         dq_i,
    output logic                    done_o,
    output logic [7:0]              rdata_o,
    output logic [19:0]             addr_o,
    output logic [7:0]              dq_o,
    output logic                    dq_oe_o,
    output logic                    ce_n_o,
    output logic                    oe_n_o,
    output logic                    we_n_o
);
    import fesq_pkg::*;

    // Read wait covers the two synchroniser stages
    localparam logic [7:0] WE_LD  = 8'(WE_CYC - 1);
    localparam logic [7:0] RD_LD  = 8'(RD_CYC + 1);
    localparam logic [7:0] REC_LD = 8'(REC_CYC - 1);

    fesq_cyc_e  st_q;
    logic [7:0] cnt_q;
    logic       is_wr_q;

    // Strobe timing; data stays driven through recovery for hold
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q    <= CYC_IDLE;
            cnt_q   <= 8'h00;
            is_wr_q <= 1'b0;
            done_o  <= 1'b0;
            rdata_o <= 8'h00;
            addr_o  <= 20'h00000;
            dq_o    <= 8'h00;
            dq_oe_o <= 1'b0;
            ce_n_o  <= 1'b1;
            oe_n_o  <= 1'b1;
            we_n_o  <= 1'b1;
        end else begin
            done_o <= 1'b0;
            case (st_q)
                CYC_IDLE: begin
                    if (req_i) begin
                        addr_o  <= req_i_s.addr;
                        dq_o    <= req_i_s.data;
                        is_wr_q <= req_i_s.we;
                        ce_n_o  <= 1'b0;
                        we_n_o  <= ~req_i_s.we;
                        oe_n_o  <= req_i_s.we;
                        dq_oe_o <= req_i_s.we;
                        cnt_q   <= req_i_s.we ? WE_LD : RD_LD;
                        st_q    <= CYC_PULSE;
                    end
                end
                CYC_PULSE: begin
                    if (cnt_q != 8'h00) begin
                        cnt_q <= cnt_q - 8'h01;
                    end else begin
                        if (!is_wr_q) begin
                            rdata_o <= dq_i;
                        end
                        ce_n_o <= 1'b1;
                        oe_n_o <= 1'b1;
                        we_n_o <= 1'b1;
                        cnt_q  <= REC_LD;
                        st_q   <= CYC_REC;
                    end
                end
                CYC_REC: begin
                    if (cnt_q != 8'h00) begin
                        cnt_q <= cnt_q - 8'h01;
                    end else begin
                        dq_oe_o <= 1'b0;
                        done_o  <= 1'b1;
                        st_q    <= CYC_IDLE;
                    end
                end
                default: st_q <= CYC_IDLE;
            endcase
        end
    end
endmodule : fesq_flash_cycle

// [logic/fesq_host.sv]
/*
 * Flash erase/write host sequencer: Wishbone register slave plus the
 * command sequencer that drives the flash parallel pins.
 * Assumes a classic Wishbone master on the same clock; flash pins are
 * plain outputs, the data bus a split in/out/enable triple.
 */
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "fesq_cfg.svh"
module fesq_host (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic      [19:0] flash_addr_o,
    output logic      [7:0]  flash_dq_o,
    output logic             flash_dq_oe_o,
    input  wire logic [7:0]  flash_dq_i,
    output logic             flash_ce_n_o,
    output logic             flash_oe_n_o,
    output logic             flash_we_n_o,
    output logic             power_down_reset_pin_n_o,
    output logic             boot_lock_n_o
);
    import fesq_pkg::*;

    // Register state
    logic [6:0]  ctrl_q;
    logic [19:0] addr_q;
    logic [7:0]  wdata_q;
    logic [7:0]  status_q;
    logic [7:0]  rdata_q;
    logic [7:0]  accum_q;
    logic        done_q;
    logic        seqerr_q;
    logic        go_q;

    // Sequencer state
    fesq_seq_e   sq_q;
    fesq_seq_e   sq_d;
    logic [2:0]  op_q;
    logic        pend_q;
    logic        req_q;
    fesq_req_s   req_s_q;
    fesq_req_s   cur_s;
    logic        cyc_done;
    logic [7:0]  cyc_rdata;
    logic [7:0]  dq_sync;
    logic [7:0]  sr_in;
    logic        wb_hit;

    // Byte lane merge for a 32-bit word
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  sel
    );
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old_v & ~m) | (new_v & m);
    endfunction : lane_merge

    // Setup code for an operation
    function automatic logic [7:0] setup_code(
        input logic [2:0] op,
        input logic       alt
    );
        case (op)
            `FESQ_OP_BERASE: setup_code = `FESQ_CMD_BERASE;
            `FESQ_OP_CERASE: setup_code = `FESQ_CMD_CERASE;
            `FESQ_OP_WRITE:  setup_code = alt ? `FESQ_CMD_WRITE2
                                              : `FESQ_CMD_WRITE;
            default:         setup_code = `FESQ_CMD_IDENT;
        endcase
    endfunction : setup_code

    // True when a polled status shows any error
    function automatic logic has_err(input logic [7:0] sr);
        return (sr & `FESQ_SR_ERRS) != 8'h00;
    endfunction : has_err

    // Read data crosses from the pins through two flops
    fesq_sync2 #(
        .W (8)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (flash_dq_i),
        .q_o   (dq_sync)
    );

    fesq_flash_cycle u_cycle (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .req_i   (req_q),
        .req_i_s (req_s_q),
        .dq_i    (dq_sync),
        .done_o  (cyc_done),
        .rdata_o (cyc_rdata),
        .addr_o  (flash_addr_o),
        .dq_o    (flash_dq_o),
        .dq_oe_o (flash_dq_oe_o),
        .ce_n_o  (flash_ce_n_o),
        .oe_n_o  (flash_oe_n_o),
        .we_n_o  (flash_we_n_o)
    );

    // Reserved bit dropped from every polled status
    assign sr_in  = cyc_rdata & `FESQ_SR_MASK;
    assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    // Wishbone answer one cycle after the strobe, dropped next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_hit;
            if (wb_hit && !wb_we_i) begin
                case (wb_adr_i)
                    `FESQ_OFS_CTRL:  wb_dat_o <= {25'h0, ctrl_q};
                    `FESQ_OFS_ADDR:  wb_dat_o <= {12'h0, addr_q};
                    `FESQ_OFS_WDATA: wb_dat_o <= {24'h0, wdata_q};
                    `FESQ_OFS_STAT:  wb_dat_o <= {6'h0, seqerr_q,
                                          has_err(accum_q), rdata_q,
                                          status_q, 6'h0, done_q,
                                          ~sq_q[0]};
                    `FESQ_OFS_ACCUM: wb_dat_o <= {24'h0, accum_q};
                    default:         wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // Software writes; a start is taken only while idle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q  <= 7'h00;
            addr_q  <= 20'h00000;
            wdata_q <= 8'h00;
            go_q    <= 1'b0;
        end else begin
            go_q <= 1'b0;
            if (wb_hit && wb_we_i) begin
                case (wb_adr_i)
                    `FESQ_OFS_CTRL: ctrl_q <= 7'(lane_merge(
                        {25'h0, ctrl_q}, wb_dat_i, wb_sel_i));
                    `FESQ_OFS_ADDR: addr_q <= 20'(lane_merge(
                        {12'h0, addr_q}, wb_dat_i, wb_sel_i));
                    `FESQ_OFS_WDATA: wdata_q <= 8'(lane_merge(
                        {24'h0, wdata_q}, wb_dat_i, wb_sel_i));
                    `FESQ_OFS_GO:   go_q <= sq_q[0] & wb_sel_i[0];
                    default:        go_q <= 1'b0;
                endcase
            end
        end
    end

    // Control pins held from flops; boot blocks locked unless opened
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            power_down_reset_pin_n_o <= 1'b0;
            boot_lock_n_o            <= 1'b0;
        end else begin
            power_down_reset_pin_n_o <= ~ctrl_q[`FESQ_CTRL_PDOWN];
            boot_lock_n_o <= ctrl_q[`FESQ_CTRL_BOOTOPEN];
        end
    end

    // Request for the current step
    always_comb begin
        cur_s = '{we: 1'b1, addr: addr_q, data: `FESQ_CMD_STATUS};
        case (sq_q)
            SQ_PRE_CMD:  cur_s.data = `FESQ_CMD_STATUS;
            SQ_PRE_POLL: cur_s.we = 1'b0;
            SQ_SETUP:    cur_s.data = setup_code(op_q,
                                          ctrl_q[`FESQ_CTRL_ALT]);
            SQ_CONFIRM:  cur_s.data = (op_q == `FESQ_OP_WRITE)
                                      ? wdata_q : `FESQ_CMD_CONFIRM;
            SQ_POLL:     cur_s.we = 1'b0;
            SQ_CLEAR:    cur_s.data = `FESQ_CMD_CLEAR;
            SQ_EXIT:     cur_s.data = `FESQ_CMD_ARRAY;
            SQ_ID_RD:    cur_s.we = 1'b0;
            default:     cur_s.we = 1'b1;
        endcase
    end

    // Next step: from idle on a start, from done at once, otherwise once the pin cycle of this one has ended, in a poll step only with ready set unless op is status
    always_comb begin
        sq_d = sq_q;
        case (sq_q)
            SQ_IDLE: begin
                if (go_q) begin
                    case (ctrl_q[2:0])
                        `FESQ_OP_CLEAR:  sq_d = SQ_CLEAR;
                        `FESQ_OP_ARRAY:  sq_d = SQ_EXIT;
                        `FESQ_OP_LOCKRD: sq_d = SQ_SETUP;
                        `FESQ_OP_READ:   sq_d = SQ_ID_RD;
                        default:         sq_d = SQ_PRE_CMD;
                    endcase
                end
            end
            SQ_PRE_CMD:  if (cyc_done) sq_d = SQ_PRE_POLL;
            SQ_PRE_POLL: begin
                if (cyc_done) begin
                    if (op_q == `FESQ_OP_STATUS) begin
                        sq_d = SQ_DONE;
                    end else if (cyc_rdata[`FESQ_SR_READY]) begin
                        sq_d = SQ_SETUP;
                    end
                end
            end
            SQ_SETUP: begin
                if (cyc_done) begin
                    sq_d = (op_q == `FESQ_OP_LOCKRD) ? SQ_ID_RD
                                                     : SQ_CONFIRM;
                end
            end
            SQ_CONFIRM:  if (cyc_done) sq_d = SQ_POLL;
            SQ_POLL: begin
                if (cyc_done && cyc_rdata[`FESQ_SR_READY]) begin
                    if (has_err(sr_in) && ctrl_q[`FESQ_CTRL_AUTOCLR]) begin
                        sq_d = SQ_CLEAR;
                    end else begin
                        sq_d = SQ_EXIT;
                    end
                end
            end
            SQ_CLEAR: begin
                if (cyc_done) begin
                    sq_d = (op_q == `FESQ_OP_CLEAR) ? SQ_DONE : SQ_EXIT;
                end
            end
            SQ_EXIT:     if (cyc_done) sq_d = SQ_DONE;
            SQ_ID_RD: begin
                if (cyc_done) begin
                    sq_d = (op_q == `FESQ_OP_LOCKRD) ? SQ_EXIT : SQ_DONE;
                end
            end
            SQ_DONE:     sq_d = SQ_IDLE;
            default:     sq_d = SQ_IDLE;
        endcase
    end

    // Step register and latched operation
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sq_q <= SQ_IDLE;
            op_q <= `FESQ_OP_STATUS;
        end else begin
            sq_q <= sq_d;
            if (go_q) begin
                op_q <= ctrl_q[2:0];
            end
        end
    end

    // One pin cycle at a time, reissued while a poll step waits for ready; pend blocks a second issue
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_q   <= 1'b0;
            pend_q  <= 1'b0;
            req_s_q <= '0;
        end else begin
            req_q <= 1'b0;
            if (cyc_done) begin
                pend_q <= 1'b0;
            end else if (!pend_q && !sq_q[0] && !sq_q[9]) begin
                req_q   <= 1'b1;
                pend_q  <= 1'b1;
                req_s_q <= cur_s;
            end
        end
    end

    // Captured status and accumulated errors across operations
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_q <= 8'h00;
            accum_q  <= 8'h00;
            seqerr_q <= 1'b0;
        end else begin
            if (cyc_done && (sq_q == SQ_POLL || sq_q == SQ_PRE_POLL)) begin
                status_q <= sr_in;
                // Sequence error is both erase and write bits
                seqerr_q <= sr_in[`FESQ_SR_ERASE] &
                            sr_in[`FESQ_SR_WRITE];
            end
            if (cyc_done && sq_q == SQ_POLL) begin
                // Errors accumulated only from the poll after an operation
                accum_q <= accum_q |
                           (sr_in & `FESQ_SR_ERRS);
            end else if (cyc_done && sq_q == SQ_CLEAR) begin
                accum_q <= 8'h00;
            end
        end
    end

    // Read data and completion flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 8'h00;
            done_q  <= 1'b0;
        end else begin
            if (cyc_done && sq_q == SQ_ID_RD) begin
                rdata_q <= cyc_rdata;
            end
            // Completion wins over the clear by a new start
            if (sq_q == SQ_DONE) begin
                done_q <= 1'b1;
            end else if (go_q) begin
                done_q <= 1'b0;
            end
        end
    end

endmodule : fesq_host

// [bench/fesq_monitor.sv]
/* Checker of the host sequencer's bus answer and flash pin cycles.
   Sees only fesq_host ports; bound after the module. */
`timescale 1ns/1ps
module fesq_monitor (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic        wb_ack_o,
    input wire logic [19:0] flash_addr_o,
    input wire logic [7:0]  flash_dq_o,
    input wire logic        flash_dq_oe_o,
    input wire logic        flash_ce_n_o,
    input wire logic        flash_oe_n_o,
    input wire logic        flash_we_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Bus answer: one cycle, only after a request
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("ack held");
    property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without request");
    // Command write: selected, driving, low two cycles
    property p_we_pulse; $fell(flash_we_n_o) |-> (!flash_ce_n_o &&
        flash_dq_oe_o) ##1 !flash_we_n_o ##1 flash_we_n_o; endproperty
    a_we_pulse: assert property (p_we_pulse)
        else $error("bad write pulse");
    property p_rd_pulse; $fell(flash_oe_n_o) |=> !flash_oe_n_o [*4]
        ##1 flash_oe_n_o; endproperty
    a_rd_pulse: assert property (p_rd_pulse)
        else $error("bad read pulse");
    // Reads never collide with the host driving dq
    property p_no_fight; !flash_oe_n_o |-> !flash_dq_oe_o &&
        flash_we_n_o && !flash_ce_n_o; endproperty
    a_no_fight: assert property (p_no_fight)
        else $error("bus contention");
    property p_addr_hold; !flash_ce_n_o && $past(!flash_ce_n_o)
        |-> $stable(flash_addr_o); endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("address moved");
    property p_data_hold; $rose(flash_we_n_o) |-> (flash_dq_oe_o &&
        $stable(flash_dq_o)) ##1 !flash_dq_oe_o; endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("data not held");
    property p_gap; $rose(flash_ce_n_o) |=> flash_ce_n_o; endproperty
    a_gap: assert property (p_gap)
        else $error("no gap between cycles");

    c_write: cover property ($fell(flash_we_n_o));
    c_read: cover property ($fell(flash_oe_n_o));
    c_bus_wr: cover property (wb_ack_o && wb_we_i);
endmodule : fesq_monitor

bind fesq_host fesq_monitor fesq_monitor_i (.*);

// [bench/fesq_flash_model.sv]
/* Behavioural flash: command decoder, sticky status word, small array.
   Assumes host pin cycles; knob_i injects faults and slowness. */
`timescale 1ns/1ps
module fesq_flash_model #(
    parameter logic [3:0] BOOT_HI = 4'hf
) (
    input  wire logic [19:0] addr_i,
    input  wire logic [7:0]  dq_i,
    input  wire logic        ce_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    input  wire logic        pd_n_i,
    input  wire logic        boot_lock_n_i,
    input  wire logic [4:0]  knob_i,
    output logic      [7:0]  dq_o
);
    // Bit 0 reads 1 so host masking shows; no suspend, 6 and 2 low
    logic [7:0] sr   = 8'h81;
    logic [7:0] pend = 8'h00;
    logic [7:0] err;
    logic [7:0] rd;
    logic       wr_op;
    logic       wr_act;
    logic [1:0] mode = 2'd0;
    logic [7:0] mem [16];

    initial foreach (mem[i]) mem[i] = 8'hff;

    // Engine: busy a while, then errors stick until cleared
    task automatic run(input logic [7:0] e);
        sr[7] = 1'b0;
        #(knob_i[4] ? 3000 : 200);
        sr = sr | e | 8'h80;
    endtask : run

    // Latched as select and strobe end together; busy ignores all but 70H
    assign wr_act = !ce_n_i && !we_n_i;
    always @(negedge wr_act) begin
        if (pd_n_i && (sr[7] || dq_i == 8'h70)) begin
            if (pend != 8'h00) begin
                wr_op = (pend == 8'h40 || pend == 8'h10);
                err = wr_op ? 8'h10 : 8'h20;
                if (knob_i[1]) err = err | 8'h08;
                else if (knob_i[2] || (pend != 8'h30 && !boot_lock_n_i
                    && addr_i[19:16] == BOOT_HI)) err = 8'h02;
                else if (!knob_i[0]) err = 8'h00;
                if (!wr_op && (dq_i != 8'hd0 || knob_i[3]))
                    err = 8'h30;
                if (wr_op && err == 8'h00) mem[addr_i[3:0]] = dq_i;
                pend = 8'h00;
                fork
                    run(err);
                join_none
            end else begin
                case (dq_i)
                    8'h70: mode = 2'd1;
                    8'hff: mode = 2'd0;
                    8'h90: mode = 2'd2;
                    8'h50: sr = sr & 8'hc5;
                    default: begin
                        pend = dq_i;
                        mode = 2'd1;
                    end
                endcase
            end
        end
    end

    // Power-down resets decoder and status word
    always @(negedge pd_n_i) begin
        sr = 8'h81;
        pend = 8'h00;
        mode = 2'd0;
    end

    // Status after commands; released bus shows the inverse
    assign rd = (mode == 2'd1) ? sr : (mode == 2'd2) ? {7'h00, knob_i[2]}
              : mem[addr_i[3:0]];
    assign dq_o = (!ce_n_i && !oe_n_i) ? rd : ~rd;
endmodule : fesq_flash_model

// [bench/tb.sv]
/* Bench of fesq_host driving a behavioural flash over Wishbone.
   Assumes fesq_monitor binds itself; the model keeps device rules. */
`timescale 1ns/1ps
`include "fesq_cfg.svh"
module tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic        wb_ack_o, flash_dq_oe_o, flash_ce_n_o, flash_oe_n_o;
    logic        flash_we_n_o, power_down_reset_pin_n_o, boot_lock_n_o;
    logic [19:0] flash_addr_o;
    logic [7:0]  flash_dq_o, flash_dq_i, model_dq;
    logic [4:0]  knob = 5'h00; // slow, bad, lock, vlow, fail
    int          errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    fesq_host fesq_host_i (.*);
    fesq_flash_model fesq_flash_model_i (
        .addr_i        (flash_addr_o),
        .dq_i          (flash_dq_i),
        .ce_n_i        (flash_ce_n_o),
        .oe_n_i        (flash_oe_n_o),
        .we_n_i        (flash_we_n_o),
        .pd_n_i        (power_down_reset_pin_n_o),
        .boot_lock_n_i (boot_lock_n_o),
        .knob_i        (knob),
        .dq_o          (model_dq)
    );
    // Shared data wire: the enabled side drives it
    assign flash_dq_i = flash_dq_oe_o ? flash_dq_o : model_dq;

    // Clock and hang guard
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // Classic cycle: hold until ack, take data, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic set(input logic [19:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, `FESQ_OFS_ADDR, {12'h000, a}, q);
        wb(1'b1, `FESQ_OFS_WDATA, {24'h000000, d}, q);
    endtask : set

    // Start one sequence, poll status until done; q is the last read
    task automatic op(input logic [31:0] ctrl, output logic [31:0] q);
        wb(1'b1, `FESQ_OFS_CTRL, ctrl, q);
        wb(1'b1, `FESQ_OFS_GO, 32'h1, q);
        wb(1'b0, `FESQ_OFS_STAT, 32'h0, q);
        chk(q[1:0], 2'b01);
        while (q[1] !== 1'b1) wb(1'b0, `FESQ_OFS_STAT, 32'h0, q);
        chk(q[1:0], 2'b10);
    endtask : op

    task automatic t_reset();
        logic [31:0] q;
        wb(1'b1, 8'h18, 32'hffff_ffff, q);
        wb(1'b0, 8'h18, 32'h0, q);
        chk(q, 32'h0);
        wb(1'b0, `FESQ_OFS_ACCUM, 32'h0, q);
        chk(q, 32'h0);
        chk({power_down_reset_pin_n_o, boot_lock_n_o}, 2'b10);
    endtask : t_reset

    // Both setup codes, slow engine, readback, erases, status mode
    task automatic t_ops();
        logic [31:0] q;
        set(20'h00003, 8'ha5);
        op(32'h23, q);
        chk(q[15:8], 8'h80);
        knob = 5'h10;
        set(20'h00004, 8'h5a);
        op(32'h2b, q);
        chk(q[15:8], 8'h80);
        op(32'h27, q);
        chk(q[23:16], 8'h5a);
        set(20'h00003, 8'h00);
        op(32'h27, q);
        chk(q[23:16], 8'ha5);
        op(32'h21, q);
        chk(q[15:8], 8'h80);
        op(32'h22, q);
        chk(q[15:8], 8'h80);
        op(32'h20, q);
        chk(q[15:8], 8'h80);
    endtask : t_ops

    // Sticky errors, accumulation, clear, auto clear, bad sequence
    task automatic t_err();
        logic [31:0] q;
        knob = 5'h01;
        op(32'h21, q);
        chk(q[15:8], 8'ha0);
        knob = 5'h02;
        op(32'h22, q);
        chk(q[15:8], 8'ha8);
        chk(q[25:24], 2'b01);
        wb(1'b0, `FESQ_OFS_ACCUM, 32'h0, q);
        chk(q[7:0], 8'h28);
        knob = 5'h01;
        op(32'h24, q);
        wb(1'b0, `FESQ_OFS_ACCUM, 32'h0, q);
        chk(q, 32'h0);
        op(32'h33, q);
        chk(q[15:8], 8'h90);
        op(32'h20, q);
        chk(q[15:8], 8'h80);
        knob = 5'h08;
        op(32'h21, q);
        chk(q[25], 1'b1);
        op(32'h24, q);
    endtask : t_err

    // Boot pin, lock bits, lock read
    task automatic t_prot();
        logic [31:0] q;
        knob = 5'h00;
        set(20'hf0000, 8'h00);
        op(32'h01, q);
        chk(q[15:8], 8'h82);
        op(32'h04, q);
        op(32'h00, q);
        chk(q[15:8], 8'h80);
        knob = 5'h04;
        op(32'h22, q);
        chk(q[15:8], 8'h82);
        op(32'h26, q);
        chk(q[23:16], 8'h01);
        wb(1'b1, `FESQ_OFS_CTRL, 32'h40, q);
        chk(power_down_reset_pin_n_o, 1'b0);
    endtask : t_prot

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_ops();
        t_err();
        t_prot();
        end_sim();
    end
endmodule : tb
